/* src/pcdo_pkg.sv */
// constants for the port c/d alternate function override block
// How it works
// - two-wire enable detaches port c bit 4 as the serial data line
// - two-wire pins open-drain: output value 0, direction from unit line output
// - port c bits 5,4 pull-up, direction and output override enables equal two-wire enable; pull-up from data and disable
// - port c 5..0 input override enable: mask and group1 or converter disable
// - port c bits 3..0 keep port settings; only input path gated
// - port c bit 6 pull-up and direction overrides follow reset-disable fuse
// - port c bits 0..6 feed pin-change sources 8..14, gated by group1
// - port d bits 0..7 feed pin-change sources 16..23
// - compare pins also carry their timer's pwm waveform
// - transmitter enabled forces port d bit 1 to output
// - port d bit 2 feeds external irq 0, bit 3 feeds irq 1
// - port d bit 4 feeds timer0 count, bit 5 feeds timer1 count
// - port d bit 4 is usart clock; sync master drives its output value, direction stays with port
// - receiver enabled forces port d bit 0 input; pull-up from data bit
// - port c bit 6 as reset pin reads data, direction, input as 0
// - fuse programmed makes port c bit 6 normal io, else reset
package pcdo_pkg;
  localparam int PC_W = 7;
  localparam int PD_W = 8;
  localparam int PC_SDA = 4;
  localparam int PC_SCL = 5;
  localparam int PC_RST = 6;
  localparam int PD_RXD = 0;
  localparam int PD_TXD = 1;
  localparam int PD_IRQ0 = 2;
  localparam int PD_IRQ1 = 3;
  localparam int PD_XCK = 4;
  localparam int PD_TIMER0_COMPARE_B_OUT = 5;
  localparam int PD_TIMER0_COMPARE_A_OUT = 6;
  localparam logic [PC_W-1:0] PC_RESET_VAL = 7'h00;
  localparam logic [PD_W-1:0] PD_RESET_VAL = 8'h00;
endpackage

/* src/pcdo_pin.sv */
// one pin's override merge and gated input register
`timescale 1ns/100ps
module pcdo_pin (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_port_data,
  input wire logic i_port_dir,
  input wire logic i_pud,
  input wire logic i_pullup_override_enable,
  input wire logic i_pullup_override_value,
  input wire logic i_direction_override_enable,
  input wire logic i_direction_override_value,
  input wire logic i_output_value_override_enable,
  input wire logic i_output_value_override_value,
  input wire logic i_input_enable_override_enable,
  input wire logic i_input_enable_override_value,
  input wire logic i_pin_in,
  output logic o_out,
  output logic o_oe,
  output logic o_pullup,
  output logic o_din
);
  logic dir;
  logic ie;
  logic din_d;
  logic din_q;
  always_comb begin
    dir = i_direction_override_enable ? i_direction_override_value : i_port_dir;
    o_oe = dir;
    o_out = i_output_value_override_enable ? i_output_value_override_value : i_port_data;
    o_pullup = i_pullup_override_enable ? i_pullup_override_value : (i_port_data & ~i_port_dir & ~i_pud);
    ie = i_input_enable_override_enable ? i_input_enable_override_value : 1'b1;
    din_d = ie & i_pin_in;
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      din_q <= 1'b0;
    end else begin
      din_q <= din_d;
    end
  end
  assign o_din = din_q;
  AST_GATED_LOW: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_input_enable_override_enable && !i_input_enable_override_value) |=> !o_din) else $error("disabled input not low");
endmodule

/* src/pcdo_top.sv */
// port c and port d alternate function override logic
`timescale 1ns/100ps
module pcdo_top
  import pcdo_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [pcdo_pkg::PC_W-1:0] i_pc_data,
  input wire logic [pcdo_pkg::PC_W-1:0] i_pc_dir,
  input wire logic [pcdo_pkg::PC_W-1:0] i_pc_pin,
  input wire logic [pcdo_pkg::PD_W-1:0] i_pd_data,
  input wire logic [pcdo_pkg::PD_W-1:0] i_pd_dir,
  input wire logic [pcdo_pkg::PD_W-1:0] i_pd_pin,
  input wire logic i_global_pullup_disable,
  input wire logic i_two_wire_enable,
  input wire logic i_sda_line_out,
  input wire logic i_scl_line_out,
  input wire logic i_reset_pin_disable_fuse,
  input wire logic i_pin_change_group1_enable,
  input wire logic i_pin_change_group2_enable,
  input wire logic [pcdo_pkg::PC_W-1:0] i_pc_pc_mask,
  input wire logic [pcdo_pkg::PD_W-1:0] i_pd_pc_mask,
  input wire logic [5:0] i_conv_digital_input_disable,
  input wire logic i_timer0_compare_a_out_enable,
  input wire logic i_timer0_compare_a_out,
  input wire logic i_timer0_compare_b_out_enable,
  input wire logic i_timer0_compare_b_out,
  input wire logic i_timer2_compare_b_out_enable,
  input wire logic i_timer2_compare_b_out,
  input wire logic i_usart_tx_enable,
  input wire logic i_usart_tx_data,
  input wire logic i_usart_rx_enable,
  input wire logic i_usart_sync_master,
  input wire logic i_usart_clock_out,
  input wire logic i_irq0_enable,
  input wire logic i_irq1_enable,
  output logic [pcdo_pkg::PC_W-1:0] o_pc_out,
  output logic [pcdo_pkg::PC_W-1:0] o_pc_oe,
  output logic [pcdo_pkg::PC_W-1:0] o_pc_pullup,
  output logic [pcdo_pkg::PC_W-1:0] o_pc_din,
  output logic [pcdo_pkg::PC_W-1:0] o_pc_data_rd,
  output logic [pcdo_pkg::PC_W-1:0] o_pc_dir_rd,
  output logic [pcdo_pkg::PD_W-1:0] o_pd_out,
  output logic [pcdo_pkg::PD_W-1:0] o_pd_oe,
  output logic [pcdo_pkg::PD_W-1:0] o_pd_pullup,
  output logic [pcdo_pkg::PD_W-1:0] o_pd_din,
  output logic [6:0] o_pc_change_src,
  output logic [7:0] o_pd_change_src,
  output logic o_sda_in,
  output logic o_scl_in,
  output logic o_external_irq_zero_in,
  output logic o_external_irq_one_in,
  output logic o_timer0_count_input,
  output logic o_timer1_count_input,
  output logic o_usart_external_clock,
  output logic o_usart_rx_in,
  output logic o_reset_pin_level
);
  import pcdo_pkg::*;

  // ----------------------------------------
  // port c override terms
  // ----------------------------------------
  logic [PC_W-1:0] c_pullup_override_enable, c_pullup_override_value, c_direction_override_enable, c_direction_override_value, c_output_value_override_enable, c_output_value_override_value, c_input_enable_override_enable, c_input_enable_override_value;
  logic [PC_W-1:0] c_pcen;
  logic [PC_W-1:0] c_din;
  logic fuse;
  assign fuse = i_reset_pin_disable_fuse;

  always_comb begin
    c_pcen = i_pc_pc_mask & {PC_W{i_pin_change_group1_enable}};
    c_pullup_override_enable = '0;
    c_pullup_override_value = '0;
    c_direction_override_enable = '0;
    c_direction_override_value = '0;
    c_output_value_override_enable = '0;
    c_output_value_override_value = '0;
    c_input_enable_override_enable = '0;
    c_input_enable_override_value = '0;
    for (int i = 0; i < 6; i++) begin
      c_input_enable_override_enable[i] = c_pcen[i] | i_conv_digital_input_disable[i];
      c_input_enable_override_value[i] = c_pcen[i];
    end
    c_pullup_override_enable[PC_SDA] = i_two_wire_enable;
    c_direction_override_enable[PC_SDA] = i_two_wire_enable;
    c_output_value_override_enable[PC_SDA] = i_two_wire_enable;
    c_pullup_override_value[PC_SDA] = i_pc_data[PC_SDA] & i_global_pullup_disable;
    c_direction_override_value[PC_SDA] = i_sda_line_out;
    c_pullup_override_enable[PC_SCL] = i_two_wire_enable;
    c_direction_override_enable[PC_SCL] = i_two_wire_enable;
    c_output_value_override_enable[PC_SCL] = i_two_wire_enable;
    c_pullup_override_value[PC_SCL] = i_pc_data[PC_SCL] & i_global_pullup_disable;
    c_direction_override_value[PC_SCL] = i_scl_line_out;
    c_pullup_override_enable[PC_RST] = fuse;
    c_pullup_override_value[PC_RST] = 1'b1;
    c_direction_override_enable[PC_RST] = fuse;
    c_input_enable_override_enable[PC_RST] = fuse | c_pcen[PC_RST];
    c_input_enable_override_value[PC_RST] = fuse;
  end

  // ----------------------------------------
  // port d override terms
  // ----------------------------------------
  logic [PD_W-1:0] d_pullup_override_enable, d_pullup_override_value, d_direction_override_enable, d_direction_override_value, d_output_value_override_enable, d_output_value_override_value, d_input_enable_override_enable, d_input_enable_override_value;
  logic [PD_W-1:0] d_pcen;

  always_comb begin
    d_pcen = i_pd_pc_mask & {PD_W{i_pin_change_group2_enable}};
    d_pullup_override_enable = '0;
    d_pullup_override_value = '0;
    d_direction_override_enable = '0;
    d_direction_override_value = '0;
    d_output_value_override_enable = '0;
    d_output_value_override_value = '0;
    d_input_enable_override_enable = d_pcen;
    d_input_enable_override_value = '1;
    d_pullup_override_enable[PD_RXD] = i_usart_rx_enable;
    d_pullup_override_value[PD_RXD] = i_pd_data[PD_RXD] & ~i_global_pullup_disable;
    d_direction_override_enable[PD_RXD] = i_usart_rx_enable;
    d_pullup_override_enable[PD_TXD] = i_usart_tx_enable;
    d_direction_override_enable[PD_TXD] = i_usart_tx_enable;
    d_direction_override_value[PD_TXD] = 1'b1;
    d_output_value_override_enable[PD_TXD] = i_usart_tx_enable;
    d_output_value_override_value[PD_TXD] = i_usart_tx_data;
    d_input_enable_override_enable[PD_IRQ0] = i_irq0_enable | d_pcen[PD_IRQ0];
    d_input_enable_override_enable[PD_IRQ1] = i_irq1_enable | d_pcen[PD_IRQ1];
    d_output_value_override_enable[PD_IRQ1] = i_timer2_compare_b_out_enable;
    d_output_value_override_value[PD_IRQ1] = i_timer2_compare_b_out;
    d_output_value_override_enable[PD_XCK] = i_usart_sync_master;
    d_output_value_override_value[PD_XCK] = i_usart_clock_out;
    d_output_value_override_enable[PD_TIMER0_COMPARE_B_OUT] = i_timer0_compare_b_out_enable;
    d_output_value_override_value[PD_TIMER0_COMPARE_B_OUT] = i_timer0_compare_b_out;
    d_output_value_override_enable[PD_TIMER0_COMPARE_A_OUT] = i_timer0_compare_a_out_enable;
    d_output_value_override_value[PD_TIMER0_COMPARE_A_OUT] = i_timer0_compare_a_out;
  end

  // ----------------------------------------
  // pin instances
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < PC_W; g++) begin : g_pc
      pcdo_pin u_pin (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_port_data(i_pc_data[g]),
        .i_port_dir(i_pc_dir[g]),
        .i_pud(i_global_pullup_disable),
        .i_pullup_override_enable(c_pullup_override_enable[g]),
        .i_pullup_override_value(c_pullup_override_value[g]),
        .i_direction_override_enable(c_direction_override_enable[g]),
        .i_direction_override_value(c_direction_override_value[g]),
        .i_output_value_override_enable(c_output_value_override_enable[g]),
        .i_output_value_override_value(c_output_value_override_value[g]),
        .i_input_enable_override_enable(c_input_enable_override_enable[g]),
        .i_input_enable_override_value(c_input_enable_override_value[g]),
        .i_pin_in(i_pc_pin[g]),
        .o_out(o_pc_out[g]),
        .o_oe(o_pc_oe[g]),
        .o_pullup(o_pc_pullup[g]),
        .o_din(c_din[g])
      );
    end
    for (g = 0; g < PD_W; g++) begin : g_pd
      pcdo_pin u_pin (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_port_data(i_pd_data[g]),
        .i_port_dir(i_pd_dir[g]),
        .i_pud(i_global_pullup_disable),
        .i_pullup_override_enable(d_pullup_override_enable[g]),
        .i_pullup_override_value(d_pullup_override_value[g]),
        .i_direction_override_enable(d_direction_override_enable[g]),
        .i_direction_override_value(d_direction_override_value[g]),
        .i_output_value_override_enable(d_output_value_override_enable[g]),
        .i_output_value_override_value(d_output_value_override_value[g]),
        .i_input_enable_override_enable(d_input_enable_override_enable[g]),
        .i_input_enable_override_value(d_input_enable_override_value[g]),
        .i_pin_in(i_pd_pin[g]),
        .o_out(o_pd_out[g]),
        .o_oe(o_pd_oe[g]),
        .o_pullup(o_pd_pullup[g]),
        .o_din(o_pd_din[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // readback and peripheral inputs
  // ----------------------------------------
  always_comb begin
    o_pc_din = c_din;
    o_pc_data_rd = i_pc_data;
    o_pc_dir_rd = i_pc_dir;
    if (!fuse) begin
      o_pc_din[PC_RST] = 1'b0;
      o_pc_data_rd[PC_RST] = 1'b0;
      o_pc_dir_rd[PC_RST] = 1'b0;
    end
  end
  // unprogrammed fuse hands the pin to the reset circuitry
  assign o_reset_pin_level = fuse ? 1'b1 : i_pc_pin[PC_RST];
  assign o_pc_change_src = c_din & {PC_W{i_pin_change_group1_enable}};
  assign o_pd_change_src = o_pd_din;
  assign o_sda_in = c_din[PC_SDA];
  assign o_scl_in = c_din[PC_SCL];
  assign o_external_irq_zero_in = o_pd_din[PD_IRQ0];
  assign o_external_irq_one_in = o_pd_din[PD_IRQ1];
  assign o_timer0_count_input = o_pd_din[PD_XCK];
  assign o_timer1_count_input = o_pd_din[PD_TIMER0_COMPARE_B_OUT];
  assign o_usart_external_clock = o_pd_din[PD_XCK];
  assign o_usart_rx_in = o_pd_din[PD_RXD];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_TW_OPEN_DRAIN: assert property (@(posedge i_clk) disable iff (i_reset)
    i_two_wire_enable |-> (o_pc_out[PC_SDA] == 1'b0 && o_pc_oe[PC_SDA] == i_sda_line_out))
    else $error("sda not open drain");
  AST_TW_SCL: assert property (@(posedge i_clk) disable iff (i_reset)
    i_two_wire_enable |-> (o_pc_out[PC_SCL] == 1'b0 && o_pc_oe[PC_SCL] == i_scl_line_out))
    else $error("scl not open drain");
  AST_PC_LOW_PASS: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_pc_oe[3:0] == i_pc_dir[3:0]) && (o_pc_out[3:0] == i_pc_data[3:0]))
    else $error("port c low bits overridden");
  AST_TX_OUT: assert property (@(posedge i_clk) disable iff (i_reset)
    i_usart_tx_enable |-> o_pd_oe[PD_TXD]) else $error("tx pin not output");
  AST_RX_IN: assert property (@(posedge i_clk) disable iff (i_reset)
    i_usart_rx_enable |-> !o_pd_oe[PD_RXD]) else $error("rx pin not input");
  AST_RST_READ: assert property (@(posedge i_clk) disable iff (i_reset)
    !fuse |-> (o_pc_data_rd[PC_RST] == 1'b0 && o_pc_dir_rd[PC_RST] == 1'b0))
    else $error("reset pin reads nonzero");
  AST_CONV_GATE: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_conv_digital_input_disable[0] && !c_pcen[0]) |=> !o_pc_din[0])
    else $error("converter gate failed");
  AST_TIMER0_COMPARE_A_OUT: assert property (@(posedge i_clk) disable iff (i_reset)
    i_timer0_compare_a_out_enable |-> o_pd_out[PD_TIMER0_COMPARE_A_OUT] == i_timer0_compare_a_out)
    else $error("compare a not on pin");
endmodule

/* bench/pcdo_periph_model.sv */
// peripheral side model: two-wire, timer and usart line outputs
`timescale 1ns/100ps
module pcdo_periph_model (
  input wire logic i_clk,
  output logic o_sda_line_out,
  output logic o_scl_line_out,
  output logic o_cmp0a,
  output logic o_cmp0b,
  output logic o_cmp2b,
  output logic o_tx_data,
  output logic o_xck_out
);
  logic [7:0] lfsr_q = 8'h5a;
  // ----------------------------------------
  // lfsr shifts every cycle, a line can keep its previous value
  // ----------------------------------------
  always @(posedge i_clk) begin
    #1 lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  assign o_sda_line_out = lfsr_q[0];
  assign o_scl_line_out = lfsr_q[1];
  assign o_cmp0a = lfsr_q[2];
  assign o_cmp0b = lfsr_q[3];
  assign o_cmp2b = lfsr_q[4];
  assign o_tx_data = lfsr_q[5];
  assign o_xck_out = lfsr_q[6];
endmodule

/* bench/port_c_d_alt_function_override_tb_top.sv */
// self-checking bench for the port c/d override block
`timescale 1ns/100ps
module port_c_d_alt_function_override_tb_top;
  import pcdo_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [6:0] i_pc_data = '0, i_pc_dir = '0, i_pc_pin = '0, i_pc_pc_mask = '0;
  logic [7:0] i_pd_data = '0, i_pd_dir = '0, i_pd_pin = '0, i_pd_pc_mask = '0;
  logic [5:0] i_conv_digital_input_disable = '0;
  logic i_global_pullup_disable = 0, i_two_wire_enable = 0, i_reset_pin_disable_fuse = 0;
  logic i_pin_change_group1_enable = 0, i_pin_change_group2_enable = 0, i_timer0_compare_a_out_enable = 0;
  logic i_timer0_compare_b_out_enable = 0, i_timer2_compare_b_out_enable = 0, i_usart_tx_enable = 0, i_usart_rx_enable = 0;
  logic i_usart_sync_master = 0, i_irq0_enable = 0, i_irq1_enable = 0;
  logic i_sda_line_out, i_scl_line_out, i_timer0_compare_a_out, i_timer0_compare_b_out;
  logic i_timer2_compare_b_out, i_usart_tx_data, i_usart_clock_out;
  logic [6:0] o_pc_out, o_pc_oe, o_pc_pullup, o_pc_din, o_pc_data_rd, o_pc_dir_rd;
  logic [7:0] o_pd_out, o_pd_oe, o_pd_pullup, o_pd_din, o_pd_change_src;
  logic [6:0] o_pc_change_src, e_pc_out, e_pc_oe, e_pc_pu, e_pc_en, e_drd, e_dirrd, pcg;
  logic [7:0] e_pd_out, e_pd_oe, e_pd_pu;
  logic o_sda_in, o_scl_in, o_external_irq_zero_in, o_external_irq_one_in, e_rst;
  logic o_timer0_count_input, o_timer1_count_input, o_usart_external_clock;
  logic o_usart_rx_in, o_reset_pin_level;
  logic [6:0] e_chg;
  logic [21:0] d;
  logic [21:0] din_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int seed_val;
  always #12.5 i_clk = ~i_clk;
  pcdo_top DUT (.*);
  pcdo_periph_model partner (.i_clk(i_clk), .o_sda_line_out(i_sda_line_out),
    .o_scl_line_out(i_scl_line_out), .o_cmp0a(i_timer0_compare_a_out),
    .o_cmp0b(i_timer0_compare_b_out), .o_cmp2b(i_timer2_compare_b_out),
    .o_tx_data(i_usart_tx_data), .o_xck_out(i_usart_clock_out));
  // ----------------------------------------
  // behavioural model of the pin overrides
  // ----------------------------------------
  always_comb begin
    pcg = i_pc_pc_mask & {7{i_pin_change_group1_enable}};
    e_pc_out = i_pc_data;
    e_pc_oe = i_pc_dir;
    e_pc_pu = i_pc_data & ~i_pc_dir & {7{~i_global_pullup_disable}};
    e_pd_out = i_pd_data;
    e_pd_oe = i_pd_dir;
    e_pd_pu = i_pd_data & ~i_pd_dir & {8{~i_global_pullup_disable}};
    if (i_two_wire_enable) begin
      e_pc_out[5:4] = 2'h0;
      e_pc_oe[5:4] = {i_scl_line_out, i_sda_line_out};
      e_pc_pu[5:4] = i_pc_data[5:4] & {2{i_global_pullup_disable}};
    end
    if (i_reset_pin_disable_fuse) begin
      e_pc_pu[6] = 1'b1;
      e_pc_oe[6] = 1'b0;
    end
    if (i_usart_rx_enable) begin
      e_pd_oe[0] = 1'b0;
      e_pd_pu[0] = i_pd_data[0] & ~i_global_pullup_disable;
    end
    if (i_usart_tx_enable) begin
      e_pd_oe[1] = 1'b1;
      e_pd_pu[1] = 1'b0;
      e_pd_out[1] = i_usart_tx_data;
    end
    if (i_timer2_compare_b_out_enable) e_pd_out[3] = i_timer2_compare_b_out;
    if (i_usart_sync_master) e_pd_out[4] = i_usart_clock_out;
    if (i_timer0_compare_b_out_enable) e_pd_out[5] = i_timer0_compare_b_out;
    if (i_timer0_compare_a_out_enable) e_pd_out[6] = i_timer0_compare_a_out;
    e_pc_en = pcg | ~{1'b0, i_conv_digital_input_disable};
    e_pc_en[6] = i_reset_pin_disable_fuse;
    e_chg = {i_pc_pin[6] & (i_reset_pin_disable_fuse | ~pcg[6]),
      i_pc_pin[5:0] & e_pc_en[5:0]} & {7{i_pin_change_group1_enable}};
    e_drd = i_pc_data & {i_reset_pin_disable_fuse, 6'h3f};
    e_dirrd = i_pc_dir & {i_reset_pin_disable_fuse, 6'h3f};
    e_rst = i_reset_pin_disable_fuse | i_pc_pin[6];
  end
  // ----------------------------------------
  // stimulus, comparison and verdict
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drive();
    logic [31:0] r0, r1, r2, r3;
    r0 = $urandom;
    r1 = $urandom;
    r2 = $urandom;
    r3 = $urandom;
    {i_pc_data, i_pc_dir, i_pc_pin} = r0[20:0];
    {i_pd_data, i_pd_dir, i_pd_pin} = r1[23:0];
    {i_pc_pc_mask, i_pd_pc_mask, i_conv_digital_input_disable} = r2[20:0];
    {i_global_pullup_disable, i_two_wire_enable, i_reset_pin_disable_fuse,
      i_pin_change_group1_enable, i_pin_change_group2_enable, i_timer0_compare_a_out_enable,
      i_timer0_compare_b_out_enable, i_timer2_compare_b_out_enable, i_usart_tx_enable, i_usart_rx_enable,
      i_usart_sync_master, i_irq0_enable, i_irq1_enable} = r3[12:0];
    if (r3[13] && !i_timer0_compare_a_out_enable) begin
      i_pd_dir[7:6] = 2'h0;
      i_pd_data[7:6] = 2'h0;
    end
    if (i_timer0_compare_a_out_enable) i_pd_dir[6] = 1'b1;
    if (i_timer0_compare_b_out_enable) i_pd_dir[5] = 1'b1;
    if (i_timer2_compare_b_out_enable) i_pd_dir[3] = 1'b1;
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(25 * 4000);
    num_errors++;
    final_report();
  end
  initial begin
    seed_val = $urandom(60);
    repeat (6) @(posedge i_clk);
    #1 i_reset = 1'b0;
    din_q.push_back(22'h0);
    for (int i = 0; i < 2000; i++) begin
      @(posedge i_clk);
      #1 d = din_q.pop_front();
      check({1'b0, o_pc_din, o_pd_din}, {1'b0, d[14:0]});
      check({1'b0, o_pc_change_src, o_pd_change_src}, {1'b0, d[21:15], d[7:0]});
      check({8'h0, o_sda_in, o_scl_in, o_external_irq_zero_in, o_external_irq_one_in,
        o_timer0_count_input, o_timer1_count_input, o_usart_external_clock, o_usart_rx_in},
        {8'h0, d[12], d[13], d[2], d[3], d[4], d[5], d[4], d[0]});
      i_reset = (i == 1000);
      drive();
      #2 check({1'b0, o_pc_out, o_pd_out}, {1'b0, e_pc_out, e_pd_out});
      check({1'b0, o_pc_oe, o_pd_oe}, {1'b0, e_pc_oe, e_pd_oe});
      check({1'b0, o_pc_pullup, o_pd_pullup}, {1'b0, e_pc_pu, e_pd_pu});
      check({2'h0, o_pc_data_rd, o_pc_dir_rd}, {2'h0, e_drd, e_dirrd});
      check({15'h0, o_reset_pin_level}, {15'h0, e_rst});
      din_q.push_back((i == 1000) ? 22'h0 : {e_chg, i_pc_pin & e_pc_en, i_pd_pin});
      if (i == 1000) begin
        #1 check({1'b0, o_pc_din, o_pd_din}, 16'h0);
      end
    end
    final_report();
  end
endmodule
